// file: pkg/ring_wake_defs.svh
`ifndef RING_WAKE_DEFS_SVH
`define RING_WAKE_DEFS_SVH

// Register indices, byte address is four times the index
`define IDX_STICKY 8'h50
`define IDX_WAKE 8'h52
`define IDX_PIN_STAT 8'h54
`define IDX_PWR 8'h56
`define IDX_LINE_CTRL 8'h5C
`define IDX_LINE_STAT 8'h5E
`define IDX_TERM 8'h62

// Pin status, sticky and wake mask bit positions
`define GP_RING 1
`define GP_GPIOA 4
`define GP_GPIOB 5
`define GP_RING2 11
`define GP_MASK 16'h0832

// Power register
`define PWR_READY 0
`define PWR_LINK_DOWN 12

// Line control register
`define LC_SLOW_RAMP 0
`define LC_BT_ENABLE 1
`define LC_OFF_HOOK 2

// Line status register
`define LS_LCS_HI 3
`define LS_OVL 4
`define LS_ROV 5
`define LS_BTD 6

// Termination register
`define TM_DTMF_HEADROOM_BOOST 0
`define TM_FJM 1
`define TM_DCT_LO 2
`define TM_DCT_HI 3
`define TERM_RESET 16'h0008
`define DCT_JAPAN 2'b01
`define DCT_FCC 2'b10
`define DCT_CTR21 2'b11

// Bus answers
`define RESP_OKAY 2'b00
`define RESP_DECERR 2'b11

// Timing and full loop drive
`define CLK_NS 40
`define BCLK_IDLE_NS 2000
`define BCLK_IDLE_CYC (((`BCLK_IDLE_NS) + (`CLK_NS) - 1) / (`CLK_NS))
`define RAMP_STEP_NS 50000
`define RAMP_STEP_CYC (((`RAMP_STEP_NS) + (`CLK_NS) - 1) / (`CLK_NS))
`define DRIVE_FULL 4'hF

`endif

// file: pkg/ring_wake_pkg.sv
package ring_wake_pkg;

    typedef struct packed {
        logic [31:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [31:0] araddr;
        logic arvalid;
        logic rready;
    } axil_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } axil_rsp_t;

    typedef struct packed {
        logic ringSensePos;
        logic ringSenseNeg;
        logic ring2Sense;
        logic gpioA;
        logic gpioB;
        logic rxOverPeak;
        logic supplyDroop;
        logic [3:0] loopCurrentCode;
    } line_in_t;

    typedef struct packed {
        logic txAtten17;
        logic [1:0] dcTermMode;
        logic headroomBoost;
        logic dcRelease;
        logic [3:0] loopDrive;
    } line_out_t;

    typedef enum logic [1:0] {WAKE_IDLE, WAKE_HIGH, WAKE_SYNC_HI} wake_state_t;

endpackage

// file: rtl/sync2.sv
`timescale 1ns/1ns
module sync2 #(
    parameter int W = 1
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            meta <= '0;
            dout <= '0;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule

// file: rtl/hook_ramp.sv
`timescale 1ns/1ns
`include "ring_wake_defs.svh"
module hook_ramp (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic offHook,
    input wire logic slowRamp,
    output logic [3:0] loopDrive
);
    logic [10:0] stepCnt;
    wire stepDone = stepCnt == 11'(`RAMP_STEP_CYC - 1);

    // Slow ramp avoids the inductive spike of an abrupt break
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            loopDrive <= 4'h0;
            stepCnt <= 11'h000;
        end else if (offHook) begin
            loopDrive <= `DRIVE_FULL;
            stepCnt <= 11'h000;
        end else if (!slowRamp) begin
            loopDrive <= 4'h0;
            stepCnt <= 11'h000;
        end else if (loopDrive != 4'h0) begin
            if (stepDone) begin
                stepCnt <= 11'h000;
                loopDrive <= loopDrive - 4'h1;
            end else begin
                stepCnt <= stepCnt + 11'h001;
            end
        end
    end

    ramp_slow_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        $fell(offHook) && slowRamp |-> loopDrive == `DRIVE_FULL ##1 loopDrive == `DRIVE_FULL)
        else $error("slow ramp dropped loop current at once");
    ramp_cut_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !offHook && !slowRamp |=> loopDrive == 4'h0)
        else $error("loop current not cut without slow ramp");
endmodule

// file: rtl/ring_wake_dtmf_headroom_boost_billing_ctrl.sv
`timescale 1ns/1ns
`include "ring_wake_defs.svh"
module ring_wake_dtmf_headroom_boost_billing_ctrl (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire ring_wake_pkg::axil_req_t busReq,
    output ring_wake_pkg::axil_rsp_t busRsp,
    input wire logic bitClk,
    input wire logic linkSync,
    input wire logic linkReset_n,
    input wire ring_wake_pkg::line_in_t lineIn,
    output logic sdataIn,
    output logic codecReady,
    output ring_wake_pkg::line_out_t lineOut
);
    import ring_wake_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Functions

    function automatic logic isIdx(input logic [31:0] a, input logic [7:0] idx);
        return (a[31:10] == 22'h0) && (a[9:2] == idx);
    endfunction

    function automatic logic [15:0] mergeLo(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] s);
        return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers

    logic [2:0] linkPins;
    line_in_t lineS;

    sync2 #(.W(3)) linkSyncer (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .din({bitClk, linkSync, linkReset_n}),
        .dout(linkPins)
    );

    sync2 #(.W($bits(line_in_t))) lineSyncer (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .din(lineIn),
        .dout(lineS)
    );

    wire bclkS = linkPins[2];
    wire syncS = linkPins[1];
    wire linkRstS_n = linkPins[0];
    wire ovlLive = lineS.rxOverPeak || lineS.supplyDroop;

    ////////////////////////////////////////////////////////////////////////////
    // Registers and bus state

    logic [15:0] stickyCfg;
    logic [15:0] wakeMask;
    logic [15:0] pinStatus;
    logic [15:0] pinEvt;
    logic linkDown;
    logic [15:0] lineCtrl;
    logic [15:0] termCfg;
    logic rovFlag;
    logic btdFlag;
    logic bclkPrev;
    logic [5:0] idleCnt;
    wake_state_t wakeState;
    logic txAtten;
    logic [1:0] dcMode;
    logic headroom;
    logic dcRelease;
    logic [3:0] loopDrive;

    logic awReady, wReady, bValid, arReady, rValid;
    logic [31:0] awAddr, wData, rData;
    logic [3:0] wStrb;
    logic [1:0] bResp, rResp;

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode

    wire doWrite = !awReady && !wReady && !bValid;
    wire wrSticky = doWrite && isIdx(awAddr, `IDX_STICKY);
    wire wrWake = doWrite && isIdx(awAddr, `IDX_WAKE);
    wire wrPin = doWrite && isIdx(awAddr, `IDX_PIN_STAT);
    wire wrPwr = doWrite && isIdx(awAddr, `IDX_PWR);
    wire wrCtrl = doWrite && isIdx(awAddr, `IDX_LINE_CTRL);
    wire wrStat = doWrite && isIdx(awAddr, `IDX_LINE_STAT);
    wire wrTerm = doWrite && isIdx(awAddr, `IDX_TERM);
    wire wrHit = wrSticky || wrWake || wrPin || wrPwr || wrCtrl || wrStat || wrTerm;
    wire [15:0] wZeros = ~mergeLo(16'hFFFF, wData, wStrb);
    wire [15:0] pinClr = wrPin ? wZeros : 16'h0000;
    wire [15:0] statClr = wrStat ? wZeros : 16'h0000;
    wire [15:0] pwrNew = mergeLo({3'h0, linkDown, 12'h000}, wData, wStrb);

    wire arTake = busReq.arvalid && arReady;
    wire [31:0] ra = busReq.araddr;
    wire [15:0] pwrRd = (16'(linkDown) << `PWR_LINK_DOWN) | (16'(codecReady) << `PWR_READY);
    wire [15:0] statRd = (16'(btdFlag) << `LS_BTD) | (16'(rovFlag) << `LS_ROV)
                         | (16'(ovlLive) << `LS_OVL) | 16'(lineS.loopCurrentCode);
    wire rdHit = isIdx(ra, `IDX_STICKY) || isIdx(ra, `IDX_WAKE) || isIdx(ra, `IDX_PIN_STAT)
                 || isIdx(ra, `IDX_PWR) || isIdx(ra, `IDX_LINE_CTRL)
                 || isIdx(ra, `IDX_LINE_STAT) || isIdx(ra, `IDX_TERM);
    wire [15:0] rdMux = isIdx(ra, `IDX_STICKY) ? stickyCfg :
                        isIdx(ra, `IDX_WAKE) ? wakeMask :
                        isIdx(ra, `IDX_PIN_STAT) ? (pinEvt | (pinStatus & stickyCfg)) :
                        isIdx(ra, `IDX_PWR) ? pwrRd :
                        isIdx(ra, `IDX_LINE_CTRL) ? lineCtrl :
                        isIdx(ra, `IDX_LINE_STAT) ? statRd :
                        isIdx(ra, `IDX_TERM) ? termCfg : 16'h0000;

    assign busRsp = '{awready: awReady, wready: wReady, bresp: bResp, bvalid: bValid,
                      arready: arReady, rdata: rData, rresp: rResp, rvalid: rValid};

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            awReady <= 1'b1;
            wReady <= 1'b1;
            bValid <= 1'b0;
            bResp <= `RESP_OKAY;
            awAddr <= 32'h0000_0000;
            wData <= 32'h0000_0000;
            wStrb <= 4'h0;
        end else begin
            if (busReq.awvalid && awReady) begin
                awReady <= 1'b0;
                awAddr <= busReq.awaddr;
            end
            if (busReq.wvalid && wReady) begin
                wReady <= 1'b0;
                wData <= busReq.wdata;
                wStrb <= busReq.wstrb;
            end
            if (doWrite) begin
                bValid <= 1'b1;
                bResp <= wrHit ? `RESP_OKAY : `RESP_DECERR;
            end
            if (bValid && busReq.bready) begin
                bValid <= 1'b0;
                awReady <= 1'b1;
                wReady <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            arReady <= 1'b1;
            rValid <= 1'b0;
            rData <= 32'h0000_0000;
            rResp <= `RESP_OKAY;
        end else if (arTake) begin
            arReady <= 1'b0;
            rValid <= 1'b1;
            rData <= {16'h0000, rdMux};
            rResp <= rdHit ? `RESP_OKAY : `RESP_DECERR;
        end else if (rValid && busReq.rready) begin
            rValid <= 1'b0;
            arReady <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration; a cold link reset clears it but keeps latched status

    wire warmDone = wakeState == WAKE_SYNC_HI && !syncS;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            stickyCfg <= 16'h0000;
            wakeMask <= 16'h0000;
            linkDown <= 1'b0;
            lineCtrl <= 16'h0000;
            termCfg <= `TERM_RESET;
        end else if (!linkRstS_n) begin
            stickyCfg <= 16'h0000;
            wakeMask <= 16'h0000;
            linkDown <= 1'b0;
            lineCtrl <= 16'h0000;
            termCfg <= `TERM_RESET;
        end else begin
            if (wrSticky) stickyCfg <= mergeLo(stickyCfg, wData, wStrb) & `GP_MASK;
            if (wrWake) wakeMask <= mergeLo(wakeMask, wData, wStrb) & `GP_MASK;
            if (warmDone) linkDown <= 1'b0;
            else if (wrPwr) linkDown <= pwrNew[`PWR_LINK_DOWN];
            if (wrCtrl) lineCtrl <= mergeLo(lineCtrl, wData, wStrb) & 16'h0007;
            if (wrTerm) termCfg <= mergeLo(termCfg, wData, wStrb) & 16'h000F;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin events and sticky latch; an event wins over a clear
    // Latch outlives a cold link reset, so the driver can re-enable and read it

    always_comb begin
        pinEvt = 16'h0000;
        pinEvt[`GP_RING] = lineS.ringSensePos || lineS.ringSenseNeg;
        pinEvt[`GP_RING2] = lineS.ring2Sense;
        pinEvt[`GP_GPIOA] = lineS.gpioA;
        pinEvt[`GP_GPIOB] = lineS.gpioB;
    end

    wire [15:0] next_pinStatus = (pinEvt & stickyCfg) | (pinStatus & ~pinClr);

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) pinStatus <= 16'h0000;
        else pinStatus <= next_pinStatus;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Wake signalling; the link clock is stopped, so sync is watched directly

    wire [15:0] armed = pinStatus & stickyCfg & wakeMask;
    wire wakeAny = |armed;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wakeState <= WAKE_IDLE;
            sdataIn <= 1'b0;
        end else if (!linkRstS_n) begin
            wakeState <= WAKE_IDLE;
            sdataIn <= 1'b0;
        end else begin
            case (wakeState)
                WAKE_IDLE: if (linkDown && wakeAny) begin
                    wakeState <= WAKE_HIGH;
                    sdataIn <= 1'b1;
                end
                WAKE_HIGH: if (syncS) wakeState <= WAKE_SYNC_HI;
                WAKE_SYNC_HI: if (!syncS) begin
                    wakeState <= WAKE_IDLE;
                    sdataIn <= 1'b0;
                end
                default: begin
                    wakeState <= WAKE_IDLE;
                    sdataIn <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Codec ready: link clock running, link up and not powered down

    wire bclkRise = bclkS && !bclkPrev;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            bclkPrev <= 1'b0;
            idleCnt <= 6'h00;
            codecReady <= 1'b0;
        end else begin
            bclkPrev <= bclkS;
            if (bclkRise) idleCnt <= 6'h00;
            else if (idleCnt != 6'(`BCLK_IDLE_CYC)) idleCnt <= idleCnt + 6'h01;
            codecReady <= idleCnt != 6'(`BCLK_IDLE_CYC) && !linkDown && linkRstS_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Termination, dialing and billing tone

    wire [1:0] termSel = termCfg[`TM_DCT_HI:`TM_DCT_LO];
    wire fjmOn = termSel == `DCT_FCC && termCfg[`TM_FJM];
    wire [1:0] next_dcMode = fjmOn ? `DCT_JAPAN : termSel;
    wire btEnable = lineCtrl[`LC_BT_ENABLE];
    wire next_rov = lineS.rxOverPeak || (rovFlag && !statClr[`LS_ROV]);
    wire next_btd = (btEnable && lineS.supplyDroop) || (btdFlag && !statClr[`LS_BTD]);

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            txAtten <= 1'b0;
            dcMode <= `DCT_FCC;
            headroom <= 1'b0;
            rovFlag <= 1'b0;
            btdFlag <= 1'b0;
            dcRelease <= 1'b0;
        end else begin
            txAtten <= termSel == `DCT_JAPAN;
            dcMode <= next_dcMode;
            headroom <= termCfg[`TM_DTMF_HEADROOM_BOOST];
            rovFlag <= next_rov;
            btdFlag <= next_btd;
            dcRelease <= btdFlag && btEnable;
        end
    end

    hook_ramp hookRamp (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .offHook(lineCtrl[`LC_OFF_HOOK]),
        .slowRamp(lineCtrl[`LC_SLOW_RAMP]),
        .loopDrive(loopDrive)
    );

    assign lineOut = '{txAtten17: txAtten, dcTermMode: dcMode, headroomBoost: headroom,
                       dcRelease: dcRelease, loopDrive: loopDrive};

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    wake_rise_a: assert property (
        wakeState == WAKE_IDLE && linkDown && wakeAny && linkRstS_n |=> $rose(sdataIn))
        else $error("wake edge missing");
    wake_hold_a: assert property (
        $fell(sdataIn) && $past(linkRstS_n) |-> $past(syncS, 2) && !$past(syncS))
        else $error("wake line dropped before sync high then low");
    wake_cause_a: assert property (
        $rose(sdataIn) |-> $past(wakeAny) && $past(linkDown))
        else $error("wake raised without armed event");
    ring_clear_a: assert property (
        wrPin && pinClr[`GP_RING] && !pinEvt[`GP_RING] |=> !pinStatus[`GP_RING])
        else $error("ring status not cleared");
    flag_reset_a: assert property (
        wrStat && statClr[`LS_ROV] && lineS.rxOverPeak |=> rovFlag)
        else $error("overload flag lost under a persisting cause");
    japan_atten_a: assert property (
        termSel == `DCT_JAPAN |=> txAtten && dcMode == `DCT_JAPAN)
        else $error("Japan mode without attenuation");
    fcc_japan_a: assert property (
        termSel == `DCT_FCC && termCfg[`TM_FJM] |=> !txAtten && dcMode == `DCT_JAPAN)
        else $error("FCC Japan bit not honoured");
    btd_gate_a: assert property (
        $rose(btdFlag) |-> $past(btEnable))
        else $error("billing tone detected while disabled");
    rov_set_a: assert property (
        lineS.rxOverPeak |=> rovFlag)
        else $error("overload flag not set");
    sticky_hold_a: assert property (
        btdFlag && !statClr[`LS_BTD] |=> btdFlag)
        else $error("billing tone flag dropped without a clear");
    release_dc_a: assert property (
        btdFlag && btEnable |=> dcRelease)
        else $error("dc termination not released");
    lcs_report_a: assert property (
        arTake && isIdx(ra, `IDX_LINE_STAT) |=> rData[`LS_LCS_HI:0] == $past(lineS.loopCurrentCode))
        else $error("loop current code misreported");
endmodule

// file: tb/ac_link_ctrl_model.sv
`timescale 1ns/1ns
module ac_link_ctrl_model (
    input wire logic clk_sys,
    input wire logic sdataIn,
    input wire logic codecReady,
    input wire logic coldReq,
    output logic bitClk,
    output logic linkSync,
    output logic linkReset_n
);
    logic halted;
    logic readySeen;
    initial begin
        bitClk = 1'b0;
        linkSync = 1'b0;
        linkReset_n = 1'b1;
        halted = 1'b0;
        readySeen = 1'b0;
        #7;
        forever begin
            #160;
            if (!halted) begin
                bitClk = ~bitClk;
            end
        end
    end
    // Link clock stands still while the codec sleeps
    // Only a drop after ready was up means sleep, not the power-up low
    always @(posedge clk_sys) begin
        if (readySeen && codecReady === 1'b0) begin
            halted <= 1'b1;
        end
        readySeen <= codecReady === 1'b1;
    end
    // Cold reset instead of a warm one while the codec sleeps
    always @(posedge coldReq) begin
        @(posedge clk_sys);
        linkReset_n <= 1'b0;
        repeat (20) @(posedge clk_sys);
        linkReset_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        halted = 1'b0;
    end
    // Warm reset before any other traffic after a wake
    always @(posedge sdataIn) begin
        repeat (10) @(posedge clk_sys);
        linkSync <= 1'b1;
        repeat (40) @(posedge clk_sys);
        linkSync <= 1'b0;
        repeat (8) @(posedge clk_sys);
        halted = 1'b0;
    end
endmodule

// file: tb/tb.sv
`timescale 1ns/1ns
`include "ring_wake_defs.svh"
module tb;
    import ring_wake_pkg::*;
    logic clk_sys;
    logic reset_n;
    logic bitClk, linkSync, linkReset_n, sdataIn, codecReady, cold;
    logic [3:0] m;
    logic [2:0] w;
    axil_req_t rq;
    axil_rsp_t rs;
    line_in_t li;
    line_out_t lo;
    int mismatches, tests_run, cyc, i, t;
    logic [7:0] lf;
    assign w = {codecReady, linkSync, sdataIn};
    ring_wake_dtmf_headroom_boost_billing_ctrl u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .busReq(rq),
        .busRsp(rs), .bitClk(bitClk), .linkSync(linkSync), .linkReset_n(linkReset_n),
        .lineIn(li), .sdataIn(sdataIn), .codecReady(codecReady), .lineOut(lo));
    ac_link_ctrl_model u_ctrl (.clk_sys(clk_sys), .sdataIn(sdataIn), .codecReady(codecReady),
        .coldReq(cold),
        .bitClk(bitClk), .linkSync(linkSync), .linkReset_n(linkReset_n));
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            mismatches++;
            summarize();
        end
    end
    ////////////////////////////////////////
    task automatic summarize();
        if (mismatches == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        tests_run++;
        if (e !== s) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wt(input int k, input logic v);
        for (int n = 0; n < 200 && w[k] !== v; n++) begin
            @(posedge clk_sys);
        end
    endtask
    task automatic wr(input logic [7:0] x, input logic [15:0] d, input logic [1:0] r = 2'h0);
        logic a, b;
        a = 1'b0;
        b = 1'b0;
        rq.awaddr <= {22'h0, x, 2'h0};
        rq.wdata <= {16'h0000, d};
        rq.wstrb <= 4'hF;
        rq.awvalid <= 1'b1;
        rq.wvalid <= 1'b1;
        while (!(a && b)) begin
            @(posedge clk_sys);
            a = a | (rs.awready === 1'b1);
            b = b | (rs.wready === 1'b1);
            rq.awvalid <= !a;
            rq.wvalid <= !b;
        end
        do @(posedge clk_sys); while (rs.bvalid !== 1'b1);
        chk("bresp", r, rs.bresp);
    endtask
    task automatic rdc(input logic [7:0] x, input logic [31:0] e, input logic [1:0] r = 2'h0);
        rq.araddr <= {22'h0, x, 2'h0};
        rq.arvalid <= 1'b1;
        do @(posedge clk_sys); while (rs.arready !== 1'b1);
        rq.arvalid <= 1'b0;
        do @(posedge clk_sys); while (rs.rvalid !== 1'b1);
        chk("rdata", e, rs.rdata);
        chk("rresp", r, rs.rresp);
    endtask
    task automatic pulse(input int k);
        li.ringSensePos <= (k == 0);
        li.gpioA <= (k == 1);
        repeat (4) @(posedge clk_sys);
        li.ringSensePos <= 1'b0;
        li.gpioA <= 1'b0;
    endtask
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    // Japan bit only counts in FCC mode; attenuation only in real Japan mode
    function automatic logic [2:0] term_exp(input logic [3:0] m);
        logic [1:0] d;
        d = (m[3:2] == `DCT_FCC && m[1]) ? `DCT_JAPAN : m[3:2];
        return {m[3:2] == `DCT_JAPAN, d};
    endfunction
    function automatic logic [31:0] ls(input logic billing_tone_detected, input logic receive_overload_flag, input logic overload_indicator);
        return {25'h0, billing_tone_detected, receive_overload_flag, overload_indicator, lf[3:0]};
    endfunction
    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    ////////////////////////////////////////
    initial begin
        rq = '0;
        rq.bready = 1'b1;
        rq.rready = 1'b1;
        li = '0;
        cold = 1'b0;
        reset_n = 1'b0;
        lf = lfsr(8'h27);
        repeat (20) @(posedge clk_sys);
        reset_n <= 1'b1;
        wt(2, 1'b1);
        rdc(`IDX_TERM, 32'h0000_0008);
        chk("dcTermMode", `DCT_FCC, lo.dcTermMode);
        rdc(8'h60, 32'h0, `RESP_DECERR);
        wr(8'h60, 16'hFFFF, `RESP_DECERR);
        for (t = 4; t < 16; t++) begin
            m = (t < 12) ? (4'(t) & 4'hE) : 4'(t);
            wr(`IDX_TERM, {12'h000, m});
            settle(2);
            chk("term", term_exp(m), {lo.txAtten17, lo.dcTermMode});
            chk("headroomBoost", m[0], lo.headroomBoost);
            rdc(`IDX_TERM, {28'h0, m});
        end
        wr(`IDX_TERM, 16'h0004);
        settle(2);
        chk("term", term_exp(4'h4), {lo.txAtten17, lo.dcTermMode});
        for (i = 0; i < 2; i++) begin
            t = i ? `GP_GPIOA : `GP_RING;
            wr(`IDX_STICKY, 16'h1 << t);
            wr(`IDX_WAKE, 16'h1 << t);
            wr(`IDX_PIN_STAT, 16'h0);
            wr(`IDX_PWR, 16'h1000);
            pulse(1 - i);
            settle(8);
            chk("sdataIn", 1'b0, sdataIn);
            pulse(i);
            wt(0, 1'b1);
            chk("sdataIn", 1'b1, sdataIn);
            wt(1, 1'b1);
            wt(1, 1'b0);
            chk("sdataIn", 1'b1, sdataIn);
            settle(5);
            chk("sdataIn", 1'b0, sdataIn);
            wt(2, 1'b1);
            rdc(`IDX_PWR, 32'h0000_0001);
            rdc(`IDX_PIN_STAT, 32'h1 << t);
            wr(`IDX_PIN_STAT, 16'h0);
            rdc(`IDX_PIN_STAT, 32'h0);
        end
        // Cold wake: config is lost, the latched ring is kept
        wr(`IDX_STICKY, 16'h0002);
        wr(`IDX_PIN_STAT, 16'h0);
        wr(`IDX_PWR, 16'h1000);
        pulse(0);
        settle(8);
        chk("sdataIn", 1'b0, sdataIn);
        cold <= 1'b1;
        wt(2, 1'b1);
        rdc(`IDX_PWR, 32'h0000_0001);
        rdc(`IDX_TERM, 32'h0000_0008);
        rdc(`IDX_PIN_STAT, 32'h0);
        wr(`IDX_STICKY, 16'h0002);
        rdc(`IDX_PIN_STAT, 32'h0000_0002);
        wr(`IDX_PIN_STAT, 16'h0);
        rdc(`IDX_PIN_STAT, 32'h0);
        // Billing flags, one random loop-current code throughout
        li.loopCurrentCode <= lf[3:0];
        li.supplyDroop <= 1'b1;
        settle(6);
        rdc(`IDX_LINE_STAT, ls(0, 0, 1));
        wr(`IDX_LINE_CTRL, 16'h0002);
        settle(6);
        chk("dcRelease", 1'b1, lo.dcRelease);
        li.supplyDroop <= 1'b0;
        li.rxOverPeak <= 1'b1;
        settle(6);
        li.rxOverPeak <= 1'b0;
        settle(6);
        rdc(`IDX_LINE_STAT, ls(1, 1, 0));
        li.supplyDroop <= 1'b1;
        li.rxOverPeak <= 1'b1;
        settle(6);
        wr(`IDX_LINE_STAT, 16'h0);
        rdc(`IDX_LINE_STAT, ls(1, 1, 1));
        li.supplyDroop <= 1'b0;
        li.rxOverPeak <= 1'b0;
        settle(4);
        rdc(`IDX_LINE_STAT, ls(1, 1, 0));
        wr(`IDX_LINE_CTRL, 16'h0000);
        wr(`IDX_LINE_STAT, 16'h0);
        rdc(`IDX_LINE_STAT, ls(0, 0, 0));
        chk("dcRelease", 1'b0, lo.dcRelease);
        // Slow ramp: one step per ramp period from full drive
        wr(`IDX_LINE_CTRL, 16'h0004);
        settle(3);
        chk("loopDrive", 4'hF, lo.loopDrive);
        wr(`IDX_LINE_CTRL, 16'h0001);
        settle(3);
        chk("loopDrive", 4'hF, lo.loopDrive);
        settle(`RAMP_STEP_CYC * 15 / 2);
        chk("loopDrive", 4'h8, lo.loopDrive);
        settle(`RAMP_STEP_CYC * 8);
        chk("loopDrive", 4'h0, lo.loopDrive);
        wr(`IDX_LINE_CTRL, 16'h0004);
        wr(`IDX_LINE_CTRL, 16'h0000);
        settle(3);
        chk("loopDrive", 4'h0, lo.loopDrive);
        summarize();
    end
endmodule
